// ---- rtl/dhrs_pkg.sv ----
// Behaviour
// RULE_01: reject reset-line lows under 5us, reset otherwise
// RULE_02: same spike filter applies during reset pulse
// RULE_03: reload identity, electrode level, settings on release
// RULE_04: reload finishes within 5ms of release edge
// RULE_05: release from sleep-in lasts at most 5ms
// RULE_06: release from sleep-out lasts at most 120ms
// RULE_07: sleep-out runs blanking; sleep-in stays blank
// RULE_08: after reset everything returns to defaults
// RULE_09: host waits 5ms before sending commands
// RULE_10: host waits 120ms before sleep-out command
// RULE_11: commands ignored until release period ends
package dhrs_pkg;

	// ==========================================================
	// timing
	localparam int MCLK_NS      = 25;
	localparam int T_REJ_NS     = 5000;
	localparam int T_FULL_NS    = 9000;
	localparam int T_LOAD_MS    = 5;
	localparam int T_REL_IN_MS  = 5;
	localparam int T_REL_OUT_MS = 120;
	localparam int NS_PER_MS    = 1000000;
	localparam int FILT_CYC     = (T_REJ_NS + MCLK_NS - 1) / MCLK_NS;
	localparam int FULL_CYC     = (T_FULL_NS + MCLK_NS - 1) / MCLK_NS;
	localparam int LOAD_CYC     = (T_LOAD_MS * NS_PER_MS) / MCLK_NS;
	localparam int REL_IN_CYC   = (T_REL_IN_MS * NS_PER_MS) / MCLK_NS;
	localparam int REL_OUT_CYC  = (T_REL_OUT_MS * NS_PER_MS) / MCLK_NS;

	// ==========================================================
	// widths
	localparam int CNT_W  = 24;
	localparam int FCNT_W = 9;
	localparam int NVM_AW = 3;
	localparam int NVM_DW = 8;
	localparam int NVM_N  = 5;
	localparam logic [NVM_AW-1:0] NVM_LAST = 3'h4;
	localparam logic [NVM_AW-1:0] NVM_A0   = 3'h0;
	localparam logic [NVM_AW-1:0] NVM_A1   = 3'h1;

	// ==========================================================
	// hardware-reset defaults (plain values)
	localparam logic [NVM_DW-1:0] ID0_DEF  = 8'h00;
	localparam logic [NVM_DW-1:0] ID1_DEF  = 8'h00;
	localparam logic [NVM_DW-1:0] ID2_DEF  = 8'h00;
	localparam logic [NVM_DW-1:0] COMMON_ELECTRODE_LEVEL_DEF = 8'h20;
	localparam logic [NVM_DW-1:0] MISC_DEF = 8'h00;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		ST_RUN,
		ST_RESET,
		ST_LOAD,
		ST_BLANK
	} dhrs_state_t;

	typedef struct packed {
		logic [NVM_DW-1:0] misc;
		logic [NVM_DW-1:0] common_electrode_level;
		logic [NVM_DW-1:0] id2;
		logic [NVM_DW-1:0] id1;
		logic [NVM_DW-1:0] id0;
	} dhrs_cfg_t;

	typedef struct packed {
		logic              rd;
		logic [NVM_AW-1:0] addr;
	} dhrs_nvm_req_t;

endpackage : dhrs_pkg

// ---- rtl/dhrs_reset_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
module dhrs_reset_seq #(
	parameter int LOAD_MAX_CYC = dhrs_pkg::LOAD_CYC,
	parameter int REL_IN_MAX   = dhrs_pkg::REL_IN_CYC,
	parameter int REL_OUT_MAX  = dhrs_pkg::REL_OUT_CYC
) (
	// clock and reset
	input  wire logic                         mclk,
	input  wire logic                         rst,
	// reset pin from host
	input  wire logic                         hw_reset_line_n,
	// power mode from core
	input  wire logic                         sleep_out,
	// non-volatile memory port
	output var  dhrs_pkg::dhrs_nvm_req_t      nvm_req,
	input  wire logic                         nvm_ack,
	input  wire logic [dhrs_pkg::NVM_DW-1:0]  nvm_data,
	// working settings
	output var  dhrs_pkg::dhrs_cfg_t          cfg,
	// control to core
	output logic                              core_reset,
	output logic                              display_blank,
	output logic                              blank_seq,
	// host command gate
	input  wire logic                         cmd_valid,
	output logic                              cmd_ready,
	output logic                              cmd_accept,
	output logic                              cmd_drop
);

	// ==========================================================
	// pin synchroniser and spike filter
	logic                          sync1_q;
	logic                          sync2_q;
	logic                          lvl_q;
	logic [dhrs_pkg::FCNT_W-1:0]   fcnt_q;
	logic                          fall;
	logic                          rise;

	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end else begin
			sync1_q <= hw_reset_line_n;
			sync2_q <= sync1_q;
		end
	end

	// level changes only after standing for the full reject time
	assign fall = lvl_q && !sync2_q && (fcnt_q == dhrs_pkg::FCNT_W'(dhrs_pkg::FILT_CYC - 1)); // RULE_01
	assign rise = !lvl_q && sync2_q && (fcnt_q == dhrs_pkg::FCNT_W'(dhrs_pkg::FILT_CYC - 1)); // RULE_02

	always_ff @(posedge mclk) begin
		if (rst) begin
			lvl_q  <= 1'b1;
			fcnt_q <= '0;
		end else if (sync2_q == lvl_q) begin
			fcnt_q <= '0; // RULE_01
		end else if (fall || rise) begin
			lvl_q  <= sync2_q;
			fcnt_q <= '0;
		end else begin
			fcnt_q <= fcnt_q + 1'b1; // RULE_02
		end
	end

	// ==========================================================
	// sequencer
	dhrs_pkg::dhrs_state_t          st_q;
	logic [dhrs_pkg::CNT_W-1:0]     rel_q;
	logic                           mode_out_q;
	logic [dhrs_pkg::NVM_AW-1:0]    idx_q;
	logic                           pend_q;
	logic                           load_done;
	logic                           load_tmo;
	logic                           rel_in_end;

	assign load_done  = pend_q && nvm_ack && (idx_q == dhrs_pkg::NVM_LAST);
	assign load_tmo   = rel_q >= dhrs_pkg::CNT_W'(LOAD_MAX_CYC - 1); // RULE_04
	assign rel_in_end = rel_q >= dhrs_pkg::CNT_W'(REL_IN_MAX - 1); // RULE_05

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q <= dhrs_pkg::ST_LOAD;
		end else if (fall) begin
			st_q <= dhrs_pkg::ST_RESET;
		end else begin
			case (st_q)
				dhrs_pkg::ST_RUN: begin
					st_q <= dhrs_pkg::ST_RUN;
				end
				dhrs_pkg::ST_RESET: begin
					if (rise) begin
						st_q <= dhrs_pkg::ST_LOAD; // RULE_03
					end
				end
				dhrs_pkg::ST_LOAD: begin
					if (load_done || load_tmo || (rel_in_end && !mode_out_q)) begin
						st_q <= mode_out_q ? dhrs_pkg::ST_BLANK : dhrs_pkg::ST_RUN; // RULE_05
					end
				end
				dhrs_pkg::ST_BLANK: begin
					if (rel_q >= dhrs_pkg::CNT_W'(REL_OUT_MAX - 1)) begin
						st_q <= dhrs_pkg::ST_RUN; // RULE_06
					end
				end
				default: begin
					st_q <= dhrs_pkg::ST_RESET;
				end
			endcase
		end
	end

	// time since the pin went high, counting the filter delay
	always_ff @(posedge mclk) begin
		if (rst) begin
			rel_q <= '0;
		end else if (rise) begin
			rel_q <= dhrs_pkg::CNT_W'(dhrs_pkg::FILT_CYC); // RULE_04
		end else if (st_q == dhrs_pkg::ST_LOAD || st_q == dhrs_pkg::ST_BLANK) begin
			rel_q <= rel_q + 1'b1;
		end
	end

	// power mode caught when the reset begins
	always_ff @(posedge mclk) begin
		if (rst) begin
			mode_out_q <= 1'b0;
		end else if (fall && st_q != dhrs_pkg::ST_RESET) begin
			mode_out_q <= sleep_out; // RULE_07
		end
	end

	// ==========================================================
	// non-volatile reload
	always_ff @(posedge mclk) begin
		if (rst || fall) begin
			idx_q   <= dhrs_pkg::NVM_A0;
			pend_q  <= 1'b0;
			nvm_req <= '0;
		end else if (st_q == dhrs_pkg::ST_LOAD && !load_tmo) begin
			if (!pend_q) begin
				nvm_req.rd   <= 1'b1; // RULE_03
				nvm_req.addr <= idx_q;
				pend_q       <= 1'b1;
			end else begin
				nvm_req.rd <= 1'b0;
				if (nvm_ack) begin
					pend_q <= 1'b0;
					idx_q  <= idx_q + dhrs_pkg::NVM_A1;
				end
			end
		end else begin
			nvm_req <= '0;
			pend_q  <= 1'b0;
			idx_q   <= dhrs_pkg::NVM_A0;
		end
	end

	logic [dhrs_pkg::NVM_DW-1:0] word_q [dhrs_pkg::NVM_N];
	localparam logic [dhrs_pkg::NVM_DW-1:0] DEF [dhrs_pkg::NVM_N] = '{
		dhrs_pkg::ID0_DEF, dhrs_pkg::ID1_DEF, dhrs_pkg::ID2_DEF,
		dhrs_pkg::COMMON_ELECTRODE_LEVEL_DEF, dhrs_pkg::MISC_DEF};

	for (genvar i = 0; i < dhrs_pkg::NVM_N; i++) begin : g_word
		always_ff @(posedge mclk) begin
			if (rst || st_q == dhrs_pkg::ST_RESET) begin
				word_q[i] <= DEF[i]; // RULE_08
			end else if (st_q == dhrs_pkg::ST_LOAD && pend_q && nvm_ack
					&& idx_q == dhrs_pkg::NVM_AW'(i)) begin
				word_q[i] <= nvm_data; // RULE_03
			end
		end
	end

	assign cfg.id0                    = word_q[0];
	assign cfg.id1                    = word_q[1];
	assign cfg.id2                    = word_q[2];
	assign cfg.common_electrode_level = word_q[3];
	assign cfg.misc                   = word_q[4];

	// ==========================================================
	// core control and blanking
	always_ff @(posedge mclk) begin
		if (rst) begin
			core_reset <= 1'b1;
		end else begin
			core_reset <= st_q != dhrs_pkg::ST_RUN; // RULE_08
		end
	end

	// display kept blank for the whole sequence
	always_ff @(posedge mclk) begin
		if (rst) begin
			display_blank <= 1'b1;
			blank_seq     <= 1'b0;
		end else begin
			display_blank <= st_q != dhrs_pkg::ST_RUN; // RULE_07
			blank_seq     <= mode_out_q && st_q != dhrs_pkg::ST_RUN; // RULE_07
		end
	end

	// ==========================================================
	// host command gate
	always_ff @(posedge mclk) begin
		if (rst) begin
			cmd_ready <= 1'b0;
		end else begin
			cmd_ready <= st_q == dhrs_pkg::ST_RUN && !fall; // RULE_11
		end
	end

	// every command answered one cycle later
	always_ff @(posedge mclk) begin
		if (rst) begin
			cmd_accept <= 1'b0;
			cmd_drop   <= 1'b0;
		end else begin
			cmd_accept <= cmd_valid && cmd_ready; // RULE_11
			cmd_drop   <= cmd_valid && !cmd_ready; // RULE_11
		end
	end

endmodule : dhrs_reset_seq
`default_nettype wire

// ---- tb/dhrs_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// reset sequencer checks
module dhrs_checker #(
	parameter int LOAD_MAX_CYC = 400,
	parameter int REL_OUT_MAX  = 1000
) (
	input wire logic                    mclk,
	input wire logic                    rst,
	input wire logic                    hw_reset_line_n,
	input wire logic                    sleep_out,
	input wire dhrs_pkg::dhrs_nvm_req_t nvm_req,
	input wire dhrs_pkg::dhrs_cfg_t     cfg,
	input wire logic                    core_reset,
	input wire logic                    display_blank,
	input wire logic                    blank_seq,
	input wire logic                    cmd_valid,
	input wire logic                    cmd_ready,
	input wire logic                    cmd_accept,
	input wire logic                    cmd_drop
);
	localparam dhrs_pkg::dhrs_cfg_t DEF = {dhrs_pkg::MISC_DEF, dhrs_pkg::COMMON_ELECTRODE_LEVEL_DEF,
		dhrs_pkg::ID2_DEF, dhrs_pkg::ID1_DEF, dhrs_pkg::ID0_DEF};
	logic [7:0]  lowc_q;
	logic [15:0] rcnt_q;
	logic [2:0]  last_a_q;
	// low run length and time since the line went high
	always_ff @(posedge mclk) begin
		if (rst || hw_reset_line_n) lowc_q <= 8'h00;
		else if (lowc_q != 8'hff) lowc_q <= lowc_q + 8'h01;
	end
	always_ff @(posedge mclk) begin
		if (rst || !hw_reset_line_n) rcnt_q <= 16'h0000;
		else if (rcnt_q != 16'hffff) rcnt_q <= rcnt_q + 16'h0001;
	end
	always_ff @(posedge mclk) begin
		if (nvm_req.rd) last_a_q <= nvm_req.addr;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	a_spike_reject: assert property ($rose(core_reset) |-> $past(lowc_q, 4) >= 8'hc7)
		else $error("reset after short low");
	a_ready_drop: assert property (lowc_q >= 8'hcd |-> !cmd_ready)
		else $error("ready during reset");
	a_cmd_answer: assert property (cmd_valid |=> cmd_accept == $past(cmd_ready) && cmd_drop == !$past(cmd_ready))
		else $error("bad command answer");
	a_addr_order: assert property (nvm_req.rd |-> nvm_req.addr == 3'h0 || nvm_req.addr == last_a_q + 3'h1)
		else $error("reload order");
	a_load_bound: assert property (nvm_req.rd |-> rcnt_q <= LOAD_MAX_CYC + 210)
		else $error("reload too late");
	a_release_bound: assert property ($rose(cmd_ready) |-> rcnt_q <= REL_OUT_MAX + 8)
		else $error("release too long");
	a_blank_reset: assert property (core_reset || blank_seq |-> display_blank)
		else $error("display not blank");
	a_blank_mode: assert property ($rose(core_reset) |-> blank_seq == $past(sleep_out, 2))
		else $error("blanking mode not taken at reset start");
	a_cfg_default: assert property ($rose(core_reset) |-> ##[0:2] cfg == DEF)
		else $error("settings not default");
	c_drop: cover property (cmd_drop);
	c_accept: cover property (cmd_accept);
	c_blank: cover property (blank_seq);
endmodule : dhrs_checker
bind dhrs_reset_seq dhrs_checker #(.LOAD_MAX_CYC(LOAD_MAX_CYC), .REL_OUT_MAX(REL_OUT_MAX)) chk_u (
	.mclk(mclk), .rst(rst), .hw_reset_line_n(hw_reset_line_n), .sleep_out(sleep_out), .nvm_req(nvm_req),
	.cfg(cfg), .core_reset(core_reset), .display_blank(display_blank), .blank_seq(blank_seq),
	.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_accept(cmd_accept), .cmd_drop(cmd_drop));
`default_nettype wire

// ---- tb/dhrs_nvm_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// settings memory, word = a0 + address
module dhrs_nvm_model (
	input  wire logic                       mclk,
	input  wire logic                       slow,
	input  wire dhrs_pkg::dhrs_nvm_req_t    req,
	output logic                            ack,
	output logic [dhrs_pkg::NVM_DW-1:0]     data
);
	logic [3:0] cnt_q = 4'h0;
	logic [2:0] a_q = 3'h0;
	// data toggles when idle
	always @(posedge mclk) begin
		ack <= 1'b0;
		data <= ~data;
		if (req.rd) begin
			a_q <= req.addr;
			cnt_q <= slow ? 4'h6 : 4'h1;
		end else if (cnt_q == 4'h1) begin
			ack <= 1'b1;
			data <= 8'ha0 + {5'h00, a_q};
			cnt_q <= 4'h0;
		end else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
	end
endmodule : dhrs_nvm_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// reset sequencer bench
module tb_top;
	localparam int LD = 400;
	localparam int RO = 1000;
	localparam dhrs_pkg::dhrs_cfg_t LOADED = 40'ha4a3a2a1a0;
	localparam dhrs_pkg::dhrs_cfg_t DEF = {dhrs_pkg::MISC_DEF, dhrs_pkg::COMMON_ELECTRODE_LEVEL_DEF,
		dhrs_pkg::ID2_DEF, dhrs_pkg::ID1_DEF, dhrs_pkg::ID0_DEF};
	logic mclk = 1'b0, rst = 1'b1, pin_n = 1'b1, slp = 1'b0, cv = 1'b0, slow = 1'b0;
	logic ack, crst, blank, bseq, rdy, acc, drp;
	logic [7:0] nd;
	logic [31:0] rs = 32'h5b;
	dhrs_pkg::dhrs_nvm_req_t req;
	dhrs_pkg::dhrs_cfg_t cfg;
	logic q[$];
	int n_mismatch = 0, checks = 0, n;
	time t0;
	dhrs_reset_seq #(.LOAD_MAX_CYC(LD), .REL_OUT_MAX(RO)) dut_u (.mclk(mclk), .rst(rst),
		.hw_reset_line_n(pin_n), .sleep_out(slp), .nvm_req(req), .nvm_ack(ack), .nvm_data(nd),
		.cfg(cfg), .core_reset(crst), .display_blank(blank), .blank_seq(bseq), .cmd_valid(cv),
		.cmd_ready(rdy), .cmd_accept(acc), .cmd_drop(drp));
	dhrs_nvm_model nvm_u (.mclk(mclk), .slow(slow), .req(req), .ack(ack), .data(nd));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xs
	task automatic chk(input logic [39:0] g, input logic [39:0] e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic complete_run();
		$display("mismatches=%0d checks=%0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run
	// c back-to-back commands, each noting its expected answer
	task automatic cmd(input int c, input logic e);
		@(negedge mclk) cv = 1'b1;
		repeat (c) begin
			q.push_back(e);
			@(negedge mclk);
		end
		cv = 1'b0;
	endtask : cmd
	task automatic pin(input logic l, input int c);
		@(negedge mclk) pin_n = l;
		repeat (c) @(negedge mclk);
	endtask : pin
	task automatic wait_rdy();
		n = 0;
		while (rdy !== 1'b1 && n < 3000) begin
			@(negedge mclk);
			n++;
		end
		if (rdy !== 1'b1) begin
			chk(40'h0, 40'h1);
		end
	endtask : wait_rdy
	initial forever #12.5 mclk = ~mclk;
	initial begin
		repeat (10000) @(posedge mclk);
		n_mismatch++;
		complete_run();
	end
	always @(posedge mclk) begin
		#1;
		if (acc === 1'b1 || drp === 1'b1) begin
			if (q.size() == 0) chk(40'h1, 40'h0);
			else chk(40'(acc), 40'(q.pop_front()));
		end
	end
	initial begin
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		cmd(1, 1'b0);
		wait_rdy();
		chk(cfg, LOADED);
		rs = xs(rs);
		cmd(int'(rs[2:0]) + 1, 1'b1);
		rs = xs(rs);
		pin(1'b0, 20 + int'(rs[6:0]));
		pin(1'b1, 300);
		chk(40'(rdy), 40'h1);
		chk(cfg, LOADED);
		slow = 1'b1;
		pin(1'b0, 250);
		pin(1'b1, 60);
		pin(1'b0, 60);
		chk(40'(crst), 40'h1);
		chk(cfg, DEF);
		cmd(2, 1'b0);
		pin(1'b1, 0);
		wait_rdy();
		chk(40'(n <= 202 + LD), 40'h1);
		chk(cfg, LOADED);
		slp = 1'b1;
		slow = 1'b0;
		pin(1'b0, 250);
		pin(1'b1, 0);
		t0 = $time;
		repeat (300) @(negedge mclk);
		chk(40'({bseq, blank}), 40'h3);
		cmd(1, 1'b0);
		wait_rdy();
		n = int'(($time - t0) / 25);
		chk(40'(n >= RO - 10 && n <= RO + 10), 40'h1);
		chk(40'({crst, bseq}), 40'h0);
		cmd(2, 1'b1);
		repeat (4) @(negedge mclk);
		chk(40'(q.size()), 40'h0);
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
